// ---- rtl/pslld_consts.vh ----
/*
  Shared constants of the serial latch and lock detect block: word layout,
  latch select codes, field positions, output source codes and lock timing.
  Assumes it is included by its bare name from every design file that uses it.
*/
`ifndef PSLLD_CONSTS_VH
`define PSLLD_CONSTS_VH

// ==========================================================================
// Serial word and latch select
`define PSLLD_WORD_W        24
`define PSLLD_WORD_MSB      23
`define PSLLD_SEL_MSB       1
`define PSLLD_SEL_LSB       0
`define PSLLD_SEL_REF       2'h0
`define PSLLD_SEL_FB        2'h1
`define PSLLD_SEL_FUNC      2'h2
`define PSLLD_SEL_INIT      2'h3

// ==========================================================================
// Field positions
`define PSLLD_REF_MSB       15
`define PSLLD_REF_LSB       2
`define PSLLD_REF_W         14
`define PSLLD_PULSE_W_MSB   17
`define PSLLD_PULSE_W_LSB   16
`define PSLLD_PRECISION_BIT 20
`define PSLLD_FB_MSB        20
`define PSLLD_FB_LSB        8
`define PSLLD_FB_W          13
`define PSLLD_GAIN_BIT      21
`define PSLLD_PUMP_HIZ_BIT  8
`define PSLLD_POLARITY_BIT  7
`define PSLLD_SRC_MSB       6
`define PSLLD_SRC_LSB       4
`define PSLLD_PDOWN_BIT     3
`define PSLLD_CNT_RST_BIT   2

// ==========================================================================
// Output source codes
`define PSLLD_SRC_HIZ       3'h0
`define PSLLD_SRC_DLOCK     3'h1
`define PSLLD_SRC_FB_DIV    3'h2
`define PSLLD_SRC_HIGH      3'h3
`define PSLLD_SRC_REF_DIV   3'h4
`define PSLLD_SRC_ALOCK     3'h5
`define PSLLD_SRC_SDATA     3'h6
`define PSLLD_SRC_LOW       3'h7

// ==========================================================================
// Lock detect timing
`define PSLLD_COUNT_COARSE  3'h3
`define PSLLD_COUNT_FINE    3'h5
`define PSLLD_LOCK_WIN_NS   15
`define PSLLD_UNLOCK_WIN_NS 25
`define PSLLD_CLK_PERIOD_NS 40
`define PSLLD_ERR_W         8

`endif

// ---- rtl/pslld_lock.v ----
/*
  Phase error measurement between divided reference and feedback pulses,
  charge pump direction and the digital lock filter.
  Assumes one-cycle pulses on the system clock; error resolution is one cycle.
*/
`include "pslld_consts.vh"

module pslld_lock #(
  parameter ERR_W = `PSLLD_ERR_W
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire run_in,
  input  wire ref_pulse_in,
  input  wire fb_pulse_in,
  input  wire fine_in,
  input  wire polarity_in,
  output reg  digital_lock_out,
  output wire error_active_out,
  output wire pump_up_out,
  output wire pump_dn_out
);

  localparam [1:0] ST_IDLE     = 2'h0;
  localparam [1:0] ST_REF_LEAD = 2'h1;
  localparam [1:0] ST_FB_LEAD  = 2'h2;
  localparam [ERR_W-1:0] ERR_ZERO = {ERR_W{1'b0}};
  localparam [ERR_W-1:0] ERR_ONE  = {{(ERR_W-1){1'b0}}, 1'b1};
  localparam [ERR_W-1:0] ERR_MAX  = {ERR_W{1'b1}};

  reg  [1:0]       state;
  reg  [ERR_W-1:0] err_cnt;
  reg  [2:0]       good_cnt;
  reg  [1:0]       next_state;
  reg  [ERR_W-1:0] next_err;
  reg              done;
  reg  [ERR_W-1:0] done_err;
  wire [ERR_W-1:0] err_inc;
  wire [31:0]      err_ns;
  wire             good;
  wire             bad;
  wire [2:0]       target;

  assign err_inc = (err_cnt == ERR_MAX) ? ERR_MAX : err_cnt + ERR_ONE;
  assign err_ns  = {{(32-ERR_W){1'b0}}, done_err} * `PSLLD_CLK_PERIOD_NS;
  assign good    = (err_ns < `PSLLD_LOCK_WIN_NS);
  assign bad     = (err_ns > `PSLLD_UNLOCK_WIN_NS);
  assign target  = fine_in ? `PSLLD_COUNT_FINE : `PSLLD_COUNT_COARSE;

  // ==========================================================================
  // Phase detector: time from leading edge to lagging edge
  always @* begin
    next_state = state;
    next_err   = err_cnt;
    done       = 1'b0;
    done_err   = err_cnt;
    case (state)
      ST_IDLE: begin
        if (ref_pulse_in && fb_pulse_in) begin
          done     = 1'b1;
          done_err = ERR_ZERO;
        end else if (ref_pulse_in) begin
          next_state = ST_REF_LEAD;
          next_err   = ERR_ONE;
        end else if (fb_pulse_in) begin
          next_state = ST_FB_LEAD;
          next_err   = ERR_ONE;
        end
      end
      ST_REF_LEAD: begin
        if (fb_pulse_in) begin
          done       = 1'b1;
          next_state = ST_IDLE;
        end else if (ref_pulse_in) begin
          // A second leading edge is a cycle slip: worst error
          done     = 1'b1;
          done_err = ERR_MAX;
          next_err = ERR_ONE;
        end else begin
          next_err = err_inc;
        end
      end
      ST_FB_LEAD: begin
        if (ref_pulse_in) begin
          done       = 1'b1;
          next_state = ST_IDLE;
        end else if (fb_pulse_in) begin
          done     = 1'b1;
          done_err = ERR_MAX;
          next_err = ERR_ONE;
        end else begin
          next_err = err_inc;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_err   = ERR_ZERO;
      end
    endcase
  end

  // ==========================================================================
  // Lock filter
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state            <= ST_IDLE;
      err_cnt          <= ERR_ZERO;
      good_cnt         <= 3'h0;
      digital_lock_out <= 1'b0;
    end else if (!run_in) begin
      state            <= ST_IDLE;
      err_cnt          <= ERR_ZERO;
      good_cnt         <= 3'h0;
      digital_lock_out <= 1'b0;
    end else begin
      state   <= next_state;
      err_cnt <= next_err;
      if (done) begin
        if (good) begin
          if (good_cnt + 3'h1 >= target) begin
            digital_lock_out <= 1'b1;
          end
          if (good_cnt < target) begin
            good_cnt <= good_cnt + 3'h1;
          end
        end else begin
          good_cnt <= 3'h0;
          if (bad) begin
            digital_lock_out <= 1'b0;
          end
        end
      end
    end
  end

  assign error_active_out = (state != ST_IDLE);
  assign pump_up_out      = polarity_in ? (state == ST_REF_LEAD) : (state == ST_FB_LEAD);
  assign pump_dn_out      = polarity_in ? (state == ST_FB_LEAD) : (state == ST_REF_LEAD);

endmodule

// ---- rtl/pslld_sync.v ----
/*
  Two-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; no relation between bits is kept.
*/
module pslld_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // ==========================================================================
  // First stage feeds only the second stage
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- rtl/pslld_top.v ----
/*
  Three-wire serial programming front end with four write-only latches,
  reference and feedback dividers, lock detection and the output pin
  multiplexer of a PLL synthesizer.
  Assumes all pins are asynchronous to CLK_SYS_IN and change far slower
  than it; serial clock edges must be at least three system cycles apart.
*/
`include "pslld_consts.vh"

module pslld_top #(
  parameter WORD_W = `PSLLD_WORD_W,
  parameter REF_W  = `PSLLD_REF_W,
  parameter FB_W   = `PSLLD_FB_W
) (
  input  wire CLK_SYS_IN,
  input  wire RSTN_IN,
  input  wire SCLK_IN,
  input  wire SDATA_IN,
  input  wire LOAD_STROBE_IN,
  input  wire POWER_ENABLE_IN,
  input  wire REF_IN,
  input  wire FB_IN,
  output reg  MULTIPLEXED_OUTPUT_PIN_OUT,
  output reg  MULTIPLEXED_OUTPUT_PIN_OE_N_OUT,
  output reg  PUMP_UP_OUT,
  output reg  PUMP_DN_OUT,
  output reg  PUMP_OE_N_OUT,
  output reg  PUMP_GAIN_SELECT_OUT,
  output reg  POWERED_DOWN_OUT
);

  localparam SYNC_W     = 6;
  localparam IX_SCLK    = 0;
  localparam IX_SDATA   = 1;
  localparam IX_STROBE  = 2;
  localparam IX_ENABLE  = 3;
  localparam IX_REF     = 4;
  localparam IX_FB      = 5;

  localparam [REF_W-1:0] REF_ZERO = {REF_W{1'b0}};
  localparam [REF_W-1:0] REF_ONE  = {{(REF_W-1){1'b0}}, 1'b1};
  localparam [FB_W-1:0]  FB_ZERO  = {FB_W{1'b0}};
  localparam [FB_W-1:0]  FB_ONE   = {{(FB_W-1){1'b0}}, 1'b1};
  localparam [WORD_W-1:0] WORD_ZERO = {WORD_W{1'b0}};

  // ==========================================================================
  // Pin synchronisation and edge detection
  wire [SYNC_W-1:0] pins_s;
  reg  [SYNC_W-1:0] pins_d;
  wire              sclk_rise;
  wire              strobe_rise;
  wire              ref_rise;
  wire              fb_rise;

  pslld_sync #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RSTN_IN),
    .async_in ({FB_IN, REF_IN, POWER_ENABLE_IN, LOAD_STROBE_IN, SDATA_IN, SCLK_IN}),
    .sync_out (pins_s)
  );

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pins_d <= {SYNC_W{1'b0}};
    end else begin
      pins_d <= pins_s;
    end
  end

  assign sclk_rise   = pins_s[IX_SCLK] & ~pins_d[IX_SCLK];
  assign strobe_rise = pins_s[IX_STROBE] & ~pins_d[IX_STROBE];
  assign ref_rise    = pins_s[IX_REF] & ~pins_d[IX_REF];
  assign fb_rise     = pins_s[IX_FB] & ~pins_d[IX_FB];

  // ==========================================================================
  // Input shift register
  reg [WORD_W-1:0] shift_word;

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      shift_word <= WORD_ZERO;
    end else if (sclk_rise) begin
      shift_word <= {shift_word[WORD_W-2:0], pins_s[IX_SDATA]};
    end
  end

  // ==========================================================================
  // Write-only latches
  reg [WORD_W-1:0] reference_divider_latch;
  reg [WORD_W-1:0] feedback_divider_latch;
  reg [WORD_W-1:0] function_control_latch;
  reg [WORD_W-1:0] initialization_control_latch;
  reg [WORD_W-1:0] active_control;
  wire [1:0]       latch_select_bits;

  assign latch_select_bits = shift_word[`PSLLD_SEL_MSB:`PSLLD_SEL_LSB];

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      reference_divider_latch      <= WORD_ZERO;
      feedback_divider_latch       <= WORD_ZERO;
      function_control_latch       <= WORD_ZERO;
      initialization_control_latch <= WORD_ZERO;
      active_control               <= WORD_ZERO;
    end else if (strobe_rise) begin
      case (latch_select_bits)
        `PSLLD_SEL_REF: begin
          reference_divider_latch <= shift_word;
        end
        `PSLLD_SEL_FB: begin
          feedback_divider_latch <= shift_word;
        end
        `PSLLD_SEL_FUNC: begin
          function_control_latch <= shift_word;
          active_control         <= shift_word;
        end
        default: begin
          initialization_control_latch <= shift_word;
          active_control               <= shift_word;
        end
      endcase
    end
  end

  // ==========================================================================
  // Decoded fields
  wire [REF_W-1:0] reference_divide_ratio;
  wire [FB_W-1:0]  feedback_divide_ratio;
  wire             lock_precision_select;
  wire [1:0]       pulse_width_select;
  wire [2:0]       output_source_select;
  wire             pump_gain_select;
  wire             pump_hiz;
  wire             phase_polarity;
  wire             soft_power_down;
  wire             counter_hold;
  wire             power_down;
  wire             run;

  assign reference_divide_ratio = reference_divider_latch[`PSLLD_REF_MSB:`PSLLD_REF_LSB];
  assign pulse_width_select     = reference_divider_latch[`PSLLD_PULSE_W_MSB:`PSLLD_PULSE_W_LSB];
  assign lock_precision_select  = reference_divider_latch[`PSLLD_PRECISION_BIT];
  assign feedback_divide_ratio  = feedback_divider_latch[`PSLLD_FB_MSB:`PSLLD_FB_LSB];
  assign pump_gain_select       = feedback_divider_latch[`PSLLD_GAIN_BIT];
  assign output_source_select   = active_control[`PSLLD_SRC_MSB:`PSLLD_SRC_LSB];
  assign pump_hiz               = active_control[`PSLLD_PUMP_HIZ_BIT];
  assign phase_polarity         = active_control[`PSLLD_POLARITY_BIT];
  assign soft_power_down        = active_control[`PSLLD_PDOWN_BIT];
  assign counter_hold           = active_control[`PSLLD_CNT_RST_BIT];

  assign power_down = ~pins_s[IX_ENABLE] | soft_power_down;
  assign run        = ~power_down & ~counter_hold;

  // ==========================================================================
  // Reference and feedback dividers
  // A zero ratio is not legal; it divides by one rather than stalling.
  reg  [REF_W-1:0] ref_cnt;
  reg  [FB_W-1:0]  fb_cnt;
  reg              ref_div_pulse;
  reg              fb_div_pulse;
  wire [REF_W-1:0] ref_last;
  wire [FB_W-1:0]  fb_last;

  assign ref_last = (reference_divide_ratio == REF_ZERO) ? REF_ZERO : reference_divide_ratio - REF_ONE;
  assign fb_last  = (feedback_divide_ratio == FB_ZERO) ? FB_ZERO : feedback_divide_ratio - FB_ONE;

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ref_cnt       <= REF_ZERO;
      ref_div_pulse <= 1'b0;
    end else if (!run) begin
      ref_cnt       <= REF_ZERO;
      ref_div_pulse <= 1'b0;
    end else begin
      ref_div_pulse <= 1'b0;
      if (ref_rise) begin
        if (ref_cnt >= ref_last) begin
          ref_cnt       <= REF_ZERO;
          ref_div_pulse <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + REF_ONE;
        end
      end
    end
  end

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fb_cnt       <= FB_ZERO;
      fb_div_pulse <= 1'b0;
    end else if (!run) begin
      fb_cnt       <= FB_ZERO;
      fb_div_pulse <= 1'b0;
    end else begin
      fb_div_pulse <= 1'b0;
      if (fb_rise) begin
        if (fb_cnt >= fb_last) begin
          fb_cnt       <= FB_ZERO;
          fb_div_pulse <= 1'b1;
        end else begin
          fb_cnt <= fb_cnt + FB_ONE;
        end
      end
    end
  end

  // ==========================================================================
  // Phase detector and lock filter
  wire digital_lock;
  wire error_active;
  wire pump_up;
  wire pump_dn;

  pslld_lock #(
    .ERR_W            (`PSLLD_ERR_W)
  ) u_lock (
    .clk_in           (CLK_SYS_IN),
    .rst_n_in         (RSTN_IN),
    .run_in           (run),
    .ref_pulse_in     (ref_div_pulse),
    .fb_pulse_in      (fb_div_pulse),
    .fine_in          (lock_precision_select),
    .polarity_in      (phase_polarity),
    .digital_lock_out (digital_lock),
    .error_active_out (error_active),
    .pump_up_out      (pump_up),
    .pump_dn_out      (pump_dn)
  );

  // ==========================================================================
  // Output multiplexer and pump drive
  reg next_mux_level;
  reg next_mux_oe_n;

  always @* begin
    next_mux_level = 1'b0;
    next_mux_oe_n  = 1'b0;
    case (output_source_select)
      `PSLLD_SRC_HIZ: begin
        next_mux_oe_n = 1'b1;
      end
      `PSLLD_SRC_DLOCK: begin
        next_mux_level = digital_lock;
      end
      `PSLLD_SRC_FB_DIV: begin
        next_mux_level = fb_div_pulse;
      end
      `PSLLD_SRC_HIGH: begin
        next_mux_level = 1'b1;
      end
      `PSLLD_SRC_REF_DIV: begin
        next_mux_level = ref_div_pulse;
      end
      `PSLLD_SRC_ALOCK: begin
        next_mux_oe_n = ~error_active;
      end
      `PSLLD_SRC_SDATA: begin
        next_mux_level = shift_word[`PSLLD_WORD_MSB];
      end
      default: begin
        next_mux_level = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      MULTIPLEXED_OUTPUT_PIN_OUT      <= 1'b0;
      MULTIPLEXED_OUTPUT_PIN_OE_N_OUT <= 1'b1;
      PUMP_UP_OUT                     <= 1'b0;
      PUMP_DN_OUT                     <= 1'b0;
      PUMP_OE_N_OUT                   <= 1'b1;
      PUMP_GAIN_SELECT_OUT            <= 1'b0;
      POWERED_DOWN_OUT                <= 1'b1;
    end else begin
      MULTIPLEXED_OUTPUT_PIN_OUT      <= next_mux_level;
      MULTIPLEXED_OUTPUT_PIN_OE_N_OUT <= next_mux_oe_n;
      PUMP_UP_OUT                     <= pump_up;
      PUMP_DN_OUT                     <= pump_dn;
      PUMP_OE_N_OUT                   <= power_down | pump_hiz;
      PUMP_GAIN_SELECT_OUT            <= pump_gain_select;
      POWERED_DOWN_OUT                <= power_down;
    end
  end

endmodule

// ---- test/pslld_host_model.sv ----
/*
  Host side of the three-wire programming link: serial clock, data, strobe.
  Assumes the system clock runs at 40 ns; serial clock period is 320 ns.
*/
module pslld_host_model (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      sdata_out,
  output logic      strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out   = 1'b0;
    sdata_out  = 1'b0;
    strobe_out = 1'b0;
  end

  // ==========================================================================
  // One word; serial clock stands low between frames
  task automatic send(input logic [23:0] word, input logic load);
    integer i;
    @(posedge clk_in);
    for (i = 23; i >= 0; i--) begin
      // Data ahead of rise, MSB first
      sdata_out <= word[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    // Released data line shows the inverse, not a stale bit
    sdata_out <= ~word[0];
    if (load) begin
      repeat (2) @(posedge clk_in);
      strobe_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      strobe_out <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ---- test/pslld_top_asserts.sv ----
/*
  Concurrent checks on the pins of pslld_top: reset release, power down,
  pump release and latch update timing.
  Assumes it is bound to pslld_top and sees only its ports.
*/
module pslld_chk (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic LOAD_STROBE_IN,
  input wire logic POWER_ENABLE_IN,
  input wire logic MULTIPLEXED_OUTPUT_PIN_OE_N_OUT,
  input wire logic PUMP_OE_N_OUT,
  input wire logic PUMP_GAIN_SELECT_OUT,
  input wire logic POWERED_DOWN_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       strobe_q;
  logic [3:0] since_strobe;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  // ==========================================================================
  // Cycles since the strobe pin last rose, saturating
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      strobe_q     <= 1'b0;
      since_strobe <= 4'hF;
    end else begin
      strobe_q <= LOAD_STROBE_IN;
      if (LOAD_STROBE_IN && !strobe_q)
        since_strobe <= 4'h0;
      else if (since_strobe != 4'hF)
        since_strobe <= since_strobe + 4'h1;
    end
  end

  // ==========================================================================
  // Sequences and properties
  sequence s_enable_off;
    !POWER_ENABLE_IN [*5];
  endsequence
  sequence s_gain_step;
    $changed(PUMP_GAIN_SELECT_OUT);
  endsequence

  property p_reset_release;
    $rose(RSTN_IN) |-> MULTIPLEXED_OUTPUT_PIN_OE_N_OUT && PUMP_OE_N_OUT && POWERED_DOWN_OUT
      && !PUMP_GAIN_SELECT_OUT;
  endproperty
  property p_enable_low_pdown;
    s_enable_off |-> POWERED_DOWN_OUT;
  endproperty
  property p_pdown_pump_hiz;
    POWERED_DOWN_OUT && $past(POWERED_DOWN_OUT) |-> PUMP_OE_N_OUT;
  endproperty
  property p_pdown_fall;
    $fell(POWERED_DOWN_OUT) |-> $past(POWER_ENABLE_IN, 3);
  endproperty
  property p_pdown_rise;
    $rose(POWERED_DOWN_OUT) |-> since_strobe <= 4'h6 || !$past(POWER_ENABLE_IN, 2)
      || !$past(POWER_ENABLE_IN, 3) || !$past(POWER_ENABLE_IN, 4);
  endproperty
  property p_pump_oe_fall;
    $fell(PUMP_OE_N_OUT) |-> !POWERED_DOWN_OUT;
  endproperty
  property p_gain_needs_strobe;
    s_gain_step |-> since_strobe <= 4'h6;
  endproperty
  property p_gain_settles;
    s_gain_step |=> $stable(PUMP_GAIN_SELECT_OUT) [*3];
  endproperty

  a_reset_release:     assert property (p_reset_release) else $error("outputs wrong after reset");
  a_enable_low_pdown:  assert property (p_enable_low_pdown) else $error("enable low not powered down");
  a_pdown_pump_hiz:    assert property (p_pdown_pump_hiz) else $error("pump driven while down");
  a_pdown_fall:        assert property (p_pdown_fall) else $error("power up without enable");
  a_pdown_rise:        assert property (p_pdown_rise) else $error("power down without cause");
  a_pump_oe_fall:      assert property (p_pump_oe_fall) else $error("pump enabled while down");
  a_gain_needs_strobe: assert property (p_gain_needs_strobe) else $error("gain moved without strobe");
  a_gain_settles:      assert property (p_gain_settles) else $error("gain moved twice");
endmodule

bind pslld_top pslld_chk i_chk (
  .CLK_SYS_IN                      (CLK_SYS_IN),
  .RSTN_IN                         (RSTN_IN),
  .LOAD_STROBE_IN                  (LOAD_STROBE_IN),
  .POWER_ENABLE_IN                 (POWER_ENABLE_IN),
  .MULTIPLEXED_OUTPUT_PIN_OE_N_OUT (MULTIPLEXED_OUTPUT_PIN_OE_N_OUT),
  .PUMP_OE_N_OUT                   (PUMP_OE_N_OUT),
  .PUMP_GAIN_SELECT_OUT            (PUMP_GAIN_SELECT_OUT),
  .POWERED_DOWN_OUT                (POWERED_DOWN_OUT)
);

// ---- test/test_pll_serial_latch_lock_detect.sv ----
/*
  Self-checking bench for pslld_top: latch select, shift order, output
  source, power down and digital lock qualification.
  Assumes the host model and the bound checker are compiled alongside.
*/
`include "pslld_consts.vh"
module test_pll_serial_latch_lock_detect;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys, rst_n, en, ref_in, fb_in;
  wire        sclk, sdata, strobe, mux, mux_oe_n, pump_oe_n, gain, pdown, pump_up, pump_dn;
  integer     failures, num_checks, i, n_hi, n_lo, n_up, n_dn;
  logic [2:0] tbl_src [0:3] = '{3'h3, 3'h7, 3'h0, 3'h3};

  // ==========================================================================
  // Clock and instances
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  pslld_host_model i_host (.clk_in(clk_sys), .sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));
  pslld_top i_dut (
    .CLK_SYS_IN(clk_sys), .RSTN_IN(rst_n), .SCLK_IN(sclk), .SDATA_IN(sdata), .LOAD_STROBE_IN(strobe),
    .POWER_ENABLE_IN(en), .REF_IN(ref_in), .FB_IN(fb_in), .MULTIPLEXED_OUTPUT_PIN_OUT(mux),
    .MULTIPLEXED_OUTPUT_PIN_OE_N_OUT(mux_oe_n), .PUMP_UP_OUT(pump_up), .PUMP_DN_OUT(pump_dn),
    .PUMP_OE_N_OUT(pump_oe_n), .PUMP_GAIN_SELECT_OUT(gain), .POWERED_DOWN_OUT(pdown));

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_n(input string what, input integer exp, input integer got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [23:0] fw(input logic [1:0] sel, input logic [2:0] src, input logic pd, input logic cr);
    fw = {17'h00000, src, pd, cr, sel};
  endfunction
  function automatic logic [23:0] ref_w(input logic prec, input logic [13:0] r);
    // Top three bits set: they must be ignored
    ref_w = {3'h7, prec, 4'h0, r, `PSLLD_SEL_REF};
  endfunction
  function automatic logic [23:0] fb_w(input logic g, input logic [12:0] n);
    fb_w = {2'h0, g, n, 6'h00, `PSLLD_SEL_FB};
  endfunction
  // Pulse pairs on 16-cycle periods; feedback lags by skew cycles
  task automatic pairs(input integer n, input integer skew);
    integer k, c;
    for (k = 0; k < n; k++) begin
      for (c = 0; c < 16; c++) begin
        @(posedge clk_sys);
        // Settled values of the previous cycle; an unknown poisons the count
        n_hi = n_hi + (mux && !mux_oe_n);
        n_lo = n_lo + (!mux && !mux_oe_n);
        n_up = n_up + pump_up;
        n_dn = n_dn + pump_dn;
        ref_in <= (c < 4);
        fb_in  <= (c >= skew && c < skew + 4);
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    failures = 0;
    num_checks = 0;
    n_hi = 0;
    n_lo = 0;
    n_up = 0;
    n_dn = 0;
    rst_n = 1'b0;
    en = 1'b1;
    ref_in = 1'b0;
    fb_in = 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("mux_oe_n", 1'b1, mux_oe_n);
    chk("pump_oe_n", 1'b1, pump_oe_n);
    chk("gain", 1'b0, gain);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("pdown", 1'b0, pdown);
    $display("test reset done");

    i_host.send(fb_w(1'b1, 13'h0001), 1'b1);
    chk("gain", 1'b1, gain);
    i_host.send(ref_w(1'b0, 14'h0001), 1'b1);
    chk("gain", 1'b1, gain);
    for (i = 0; i < 4; i++) begin
      i_host.send(fw(i[0] ? `PSLLD_SEL_INIT : `PSLLD_SEL_FUNC, tbl_src[i], 1'b0, 1'b0), 1'b1);
      chk("mux_oe_n", tbl_src[i] == 3'h0, mux_oe_n);
      if (tbl_src[i] != 3'h0)
        chk("mux", !tbl_src[i][2], mux);
    end
    $display("test latch select done");

    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_SDATA, 1'b0, 1'b0) | 24'h800000, 1'b1);
    chk("mux", 1'b1, mux);
    i_host.send(fb_w(1'b0, 13'h0001), 1'b0);
    chk("mux", 1'b0, mux);
    chk("gain", 1'b1, gain);
    i_host.send(fb_w(1'b0, 13'h0001), 1'b1);
    chk("gain", 1'b0, gain);
    $display("test shift done");

    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_HIGH, 1'b1, 1'b0), 1'b1);
    chk("pdown", 1'b1, pdown);
    chk("pump_oe_n", 1'b1, pump_oe_n);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_HIGH, 1'b0, 1'b0), 1'b1);
    en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("pdown", 1'b1, pdown);
    en <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("pdown", 1'b0, pdown);
    $display("test power done");

    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_DLOCK, 1'b0, 1'b1), 1'b1);
    chk("mux", 1'b0, mux);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_DLOCK, 1'b0, 1'b0), 1'b1);
    pairs(2, 0);
    chk("mux", 1'b0, mux);
    pairs(1, 0);
    chk("mux", 1'b1, mux);
    pairs(1, 2);
    chk("mux", 1'b0, mux);
    i_host.send(ref_w(1'b1, 14'h0001), 1'b1);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_DLOCK, 1'b0, 1'b1), 1'b1);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_DLOCK, 1'b0, 1'b0), 1'b1);
    pairs(4, 0);
    chk("mux", 1'b0, mux);
    pairs(1, 0);
    chk("mux", 1'b1, mux);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_ALOCK, 1'b0, 1'b0), 1'b1);
    chk("mux_oe_n", 1'b1, mux_oe_n);
    n_lo = 0;
    n_up = 0;
    n_dn = 0;
    // Feedback two cycles late: error window and pump pulse last two cycles
    pairs(1, 2);
    chk_n("alock low cycles", 2, n_lo);
    chk_n("pump down cycles", 2, n_dn);
    chk_n("pump up cycles", 0, n_up);
    $display("test lock done");

    i_host.send(ref_w(1'b0, 14'h0002), 1'b1);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_REF_DIV, 1'b0, 1'b0), 1'b1);
    n_hi = 0;
    pairs(4, 0);
    chk_n("ref pulses", 2, n_hi);
    i_host.send(fb_w(1'b0, 13'h0003), 1'b1);
    i_host.send(fw(`PSLLD_SEL_FUNC, `PSLLD_SRC_FB_DIV, 1'b0, 1'b0), 1'b1);
    n_hi = 0;
    pairs(6, 0);
    chk_n("fb pulses", 2, n_hi);
    $display("test divider done");
    report_and_stop();
  end
endmodule
